// ==== design/sdipo_pkg.sv ====
package sdipo_pkg;

   // ******************************************************************
   // Bus geometry and field positions
   // ******************************************************************
   localparam int DATA_W      = 20;
   localparam int WORD_W      = 10;
   localparam int TS_W        = 8;
   localparam int HI_LSB      = 10;
   localparam int TS_ERR_BIT  = 19;
   localparam int TS_SYNC_BIT = 18;
   localparam int SYNC_STAGES = 3;

   // ******************************************************************
   // Host register map
   // ******************************************************************
   localparam int              REG_ADDR_W      = 12;
   localparam int              REG_DATA_W      = 16;
   localparam logic [11:0]     PCLK_DELAY_ADDR = 12'h06c;
   localparam logic [15:0]     PCLK_DELAY_RST  = 16'h0000;
   localparam int              QUAD_SEL_BIT    = 5;
   localparam int              FINE_W          = 5;
   localparam int              DELAY_CTRL_W    = 6;
   // Nominal fine step and span of the analog delay cell, in ps.
   localparam int              DELAY_STEP_PS   = 40;
   localparam int              DELAY_MAX_PS    = 1200;

   // ******************************************************************
   // Rate codes and enumerations
   // ******************************************************************
   localparam logic [1:0] RATE_CODE_HD = 2'h0;
   localparam logic [1:0] RATE_CODE_3G = 2'h2;

   typedef enum logic [2:0] {
      MODE_VIDEO = 3'h1,
      MODE_TS    = 3'h2,
      MODE_THRU  = 3'h4
   } sdipo_mode_e;

   // Pixel clock synthesiser selection; the 1.001 pull-down is separate.
   typedef enum logic [3:0] {
      RATE_13M5  = 4'h1,
      RATE_27M   = 4'h2,
      RATE_74M25 = 4'h4,
      RATE_148M5 = 4'h8
   } sdipo_rate_e;

   typedef enum logic [1:0] {
      ST_FIRST  = 2'h1,
      ST_SECOND = 2'h2
   } sdipo_state_e;

   typedef struct packed {
      logic [9:0] wordA;
      logic [9:0] wordB;
      logic [7:0] tsByte;
      logic       syncCharacterFlag;
      logic       codeErrorFlag;
   } sdipo_pair_s;

   typedef struct packed {
      logic       videoProcessingSelect;
      logic       transportStreamSelect;
      logic       busWidthSelect;
      logic       autoDetectEnable;
      logic       streamSwap;
      logic       fracRate;
      logic [1:0] rateSelect;
      logic [1:0] rateDetected;
   } sdipo_cfg_s;

   // ******************************************************************
   // Shared decoders
   // ******************************************************************
   function automatic sdipo_mode_e decode_mode(input sdipo_cfg_s cfg);
      if (!cfg.autoDetectEnable && !cfg.videoProcessingSelect && cfg.transportStreamSelect) begin
         return MODE_TS;
      end else if (cfg.videoProcessingSelect) begin
         return MODE_VIDEO;
      end else begin
         return MODE_THRU;
      end
   endfunction : decode_mode

   function automatic sdipo_rate_e decode_rate(input logic busWide, input logic [1:0] code);
      if (code[0]) begin
         return busWide ? RATE_13M5 : RATE_27M;
      end else if (code == RATE_CODE_3G) begin
         return RATE_148M5;
      end else begin
         return busWide ? RATE_74M25 : RATE_148M5;
      end
   endfunction : decode_rate

endpackage : sdipo_pkg

// ==== design/sdipo_par_out.sv ====
`timescale 1ns/1ps

module sdipo_par_out (
   // Core clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Link clock, two ticks per output word
   input  wire logic                          pixClk,
   // Mode pins and host control bits
   input  wire logic                          videoProcessingSelect,
   input  wire logic                          transportStreamSelect,
   input  wire logic                          busWidthSelect,
   input  wire logic                          autoDetectEnable,
   input  wire logic                          streamSwap,
   input  wire logic                          fracRate,
   input  wire logic [1:0]                    rateSelect,
   input  wire logic [1:0]                    rateDetected,
   // Word pairs from the receive pipeline
   input  wire logic                          wordValid,
   input  wire sdipo_pkg::sdipo_pair_s        wordIn,
   output logic                               wordReady,
   // Host register port
   input  wire logic                          regWrEn,
   input  wire logic                          regRdEn,
   input  wire logic [11:0]                   regAddr,
   input  wire logic [15:0]                   regWrData,
   output logic [15:0]                        regRdData,
   // Parallel output bus and clock controls
   output logic [19:0]                        dataOut,
   output logic                               pclkOut,
   output logic                               clockQuadratureSelect,
   output logic [4:0]                         clockFineDelay,
   output sdipo_pkg::sdipo_rate_e             pclkRateSel,
   output logic                               pclkFracSel,
   output logic                               ddrActive,
   output sdipo_pkg::sdipo_mode_e             modeStatus
);

   // ******************************************************************
   // Core domain: word hand-off and host register
   // ******************************************************************
   sdipo_pkg::sdipo_pair_s holdReg;
   logic                   reqToggle_reg;
   logic [2:0]             ackSync_reg;
   logic                   wordReady_reg;
   logic [5:0]             delayCtrl_reg;
   logic                   delayToggle_reg;
   logic [15:0]            regRdData_reg;
   logic                   ackToggle_reg;

   assign wordReady = wordReady_reg;
   assign regRdData = regRdData_reg;

   // A pair is held steady until the link side acknowledges it, so the
   // multi-bit hold register never changes while it is being sampled.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         holdReg       <= '0;
         reqToggle_reg <= 1'h0;
         wordReady_reg <= 1'h0;
      end else if (wordValid && wordReady_reg) begin
         holdReg       <= wordIn;
         reqToggle_reg <= ~reqToggle_reg;
         wordReady_reg <= 1'h0;
      end else begin
         wordReady_reg <= (ackSync_reg[1] == ackSync_reg[2]) &&
                          (ackSync_reg[2] == reqToggle_reg);
      end
   end

   // Acknowledge toggle from the link side, three stages deep.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ackSync_reg <= 3'h0;
      end else begin
         ackSync_reg <= {ackSync_reg[1:0], ackToggle_reg};
      end
   end

   // Delay line control; reserved bits above bit 5 read as zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         delayCtrl_reg   <= sdipo_pkg::PCLK_DELAY_RST[5:0];
         delayToggle_reg <= 1'h0;
      end else if (regWrEn && (regAddr == sdipo_pkg::PCLK_DELAY_ADDR)) begin
         delayCtrl_reg   <= regWrData[5:0];
         delayToggle_reg <= ~delayToggle_reg;
      end
   end

   // Register read; unmapped addresses read as zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regRdData_reg <= 16'h0000;
      end else if (regRdEn) begin
         if (regAddr == sdipo_pkg::PCLK_DELAY_ADDR) begin
            regRdData_reg <= {10'h000, delayCtrl_reg};
         end else begin
            regRdData_reg <= 16'h0000;
         end
      end
   end

   // ******************************************************************
   // Link domain: synchronisers
   // ******************************************************************
   sdipo_pkg::sdipo_cfg_s  cfgPins;
   sdipo_pkg::sdipo_cfg_s  cfgS1;
   sdipo_pkg::sdipo_cfg_s  cfgS2;
   sdipo_pkg::sdipo_cfg_s  cfgS3;
   sdipo_pkg::sdipo_cfg_s  cfgReg;
   logic [2:0]             reqSync_reg;
   logic [2:0]             dlySync_reg;
   logic                   dlySeen_reg;

   assign cfgPins = '{videoProcessingSelect, transportStreamSelect, busWidthSelect,
                      autoDetectEnable, streamSwap, fracRate, rateSelect, rateDetected};

   // Pins are accepted only once stages two and three agree, which hides
   // a vector caught halfway through a change.
   always_ff @(posedge pixClk or posedge rst) begin
      if (rst) begin
         cfgS1  <= '0;
         cfgS2  <= '0;
         cfgS3  <= '0;
         cfgReg <= '0;
      end else begin
         cfgS1 <= cfgPins;
         cfgS2 <= cfgS1;
         cfgS3 <= cfgS2;
         if (cfgS2 == cfgS3) begin
            cfgReg <= cfgS3;
         end
      end
   end

   // Request and delay-write toggles from the core domain.
   always_ff @(posedge pixClk or posedge rst) begin
      if (rst) begin
         reqSync_reg <= 3'h0;
         dlySync_reg <= 3'h0;
      end else begin
         reqSync_reg <= {reqSync_reg[1:0], reqToggle_reg};
         dlySync_reg <= {dlySync_reg[1:0], delayToggle_reg};
      end
   end

   // ******************************************************************
   // Link domain: mode and clock rate selection
   // ******************************************************************
   sdipo_pkg::sdipo_mode_e modeReg;
   sdipo_pkg::sdipo_rate_e rateReg;
   logic [1:0]             rateCode;
   logic                   is3g;
   logic                   narrowBus;
   logic                   ddrActive_reg;
   logic                   fracSel_reg;

   // Manual rate code unless auto-detect is on.
   assign rateCode  = cfgReg.autoDetectEnable ? cfgReg.rateDetected : cfgReg.rateSelect;
   assign is3g      = (modeReg == sdipo_pkg::MODE_VIDEO) && (rateCode == sdipo_pkg::RATE_CODE_3G);
   assign narrowBus = (modeReg == sdipo_pkg::MODE_TS) || !cfgReg.busWidthSelect;

   // Mode, rate and DDR flags all follow the same settled pin set, so they
   // always change together and never disagree for a tick.
   always_ff @(posedge pixClk or posedge rst) begin
      if (rst) begin
         modeReg       <= sdipo_pkg::MODE_THRU;
         rateReg       <= sdipo_pkg::RATE_148M5;
         ddrActive_reg <= 1'h0;
         fracSel_reg   <= 1'h0;
      end else begin
         modeReg       <= sdipo_pkg::decode_mode(cfgReg);
         rateReg       <= sdipo_pkg::decode_rate(cfgReg.busWidthSelect, rateCode);
         ddrActive_reg <= (sdipo_pkg::decode_mode(cfgReg) == sdipo_pkg::MODE_VIDEO) &&
                          (rateCode == sdipo_pkg::RATE_CODE_3G) &&
                          !cfgReg.busWidthSelect;
         fracSel_reg   <= cfgReg.fracRate;
      end
   end

   assign modeStatus  = modeReg;
   assign pclkRateSel = rateReg;
   assign ddrActive   = ddrActive_reg;
   assign pclkFracSel = fracSel_reg;

   // ******************************************************************
   // Link domain: pixel clock and delay line
   // ******************************************************************
   logic       divPhase_reg;
   logic       pclk_reg;
   logic       pclkNext;
   logic       slotTick;
   logic       dlyPend_reg;
   logic [5:0] dlyShadow_reg;
   logic       quad_reg;
   logic [4:0] fine_reg;

   // Words change every second link tick. In SDR the clock toggles each
   // tick; in DDR it toggles between word changes so both edges sit mid-word.
   assign slotTick = divPhase_reg;
   assign pclkNext = (!ddrActive_reg || !divPhase_reg) ? ~pclk_reg : pclk_reg;

   always_ff @(posedge pixClk or posedge rst) begin
      if (rst) begin
         divPhase_reg <= 1'h0;
         pclk_reg     <= 1'h0;
      end else begin
         divPhase_reg <= ~divPhase_reg;
         pclk_reg     <= pclkNext;
      end
   end

   // The new delay is caught once the write toggle has settled; the core
   // holds the value steady, but two writes closer than a few link ticks
   // may leave the first one unseen.
   always_ff @(posedge pixClk or posedge rst) begin
      if (rst) begin
         dlySeen_reg   <= 1'h0;
         dlyPend_reg   <= 1'h0;
         dlyShadow_reg <= sdipo_pkg::PCLK_DELAY_RST[5:0];
      end else if ((dlySync_reg[1] == dlySync_reg[2]) && (dlySync_reg[2] != dlySeen_reg)) begin
         dlySeen_reg   <= dlySync_reg[2];
         dlyPend_reg   <= 1'h1;
         dlyShadow_reg <= delayCtrl_reg;
      end else if (!pclkNext) begin
         dlyPend_reg   <= 1'h0;
      end
   end

   // Apply the delay only while the clock is about to sit low, so the
   // delay cell never slices a high phase short.
   always_ff @(posedge pixClk or posedge rst) begin
      if (rst) begin
         quad_reg <= 1'h0;
         fine_reg <= 5'h00;
      end else if (dlyPend_reg && !pclkNext) begin
         quad_reg <= dlyShadow_reg[sdipo_pkg::QUAD_SEL_BIT];
         fine_reg <= dlyShadow_reg[sdipo_pkg::FINE_W-1:0];
      end
   end

   assign pclkOut               = pclk_reg;
   assign clockQuadratureSelect = quad_reg;
   assign clockFineDelay        = fine_reg;

   // ******************************************************************
   // Link domain: word capture and output formatting
   // ******************************************************************
   sdipo_pkg::sdipo_pair_s  pendReg;
   sdipo_pkg::sdipo_pair_s  curPair;
   sdipo_pkg::sdipo_state_e state_reg;
   logic                    pendValid_reg;
   logic                    takePend;
   logic [19:0]             dataOut_reg;

   assign takePend = slotTick && (state_reg == sdipo_pkg::ST_FIRST) && pendValid_reg;

   // Builds one bus word from a pair; second selects the later half.
   function automatic logic [19:0] format_word(input sdipo_pkg::sdipo_mode_e mode,
                                               input logic wide, input logic swap,
                                               input sdipo_pkg::sdipo_pair_s p,
                                               input logic second);
      logic [9:0] pick;
      pick = (second ^ swap) ? p.wordB : p.wordA;
      if (mode == sdipo_pkg::MODE_TS) begin
         format_word = {p.codeErrorFlag, p.syncCharacterFlag, p.tsByte, 10'h000};
      end else if (wide) begin
         format_word = swap ? {p.wordB, p.wordA} : {p.wordA, p.wordB};
      end else begin
         format_word = {pick, 10'h000};
      end
   endfunction : format_word

   // A pair is taken only when the slot is free, so set and clear never meet.
   always_ff @(posedge pixClk or posedge rst) begin
      if (rst) begin
         pendValid_reg <= 1'h0;
         pendReg       <= '0;
         ackToggle_reg <= 1'h0;
      end else if (!pendValid_reg && (reqSync_reg[1] == reqSync_reg[2]) &&
                   (reqSync_reg[2] != ackToggle_reg)) begin
         pendValid_reg <= 1'h1;
         pendReg       <= holdReg;
         ackToggle_reg <= reqSync_reg[2];
      end else if (takePend) begin
         pendValid_reg <= 1'h0;
      end
   end

   // Flags ride with the byte they were raised for, so each output word
   // carries its own sync and error marks; raw words pass untouched.
   always_ff @(posedge pixClk or posedge rst) begin
      if (rst) begin
         state_reg   <= sdipo_pkg::ST_FIRST;
         curPair     <= '0;
         dataOut_reg <= 20'h0_0000;
      end else if (slotTick) begin
         case (state_reg)
            sdipo_pkg::ST_FIRST: begin
               if (pendValid_reg) begin
                  curPair     <= pendReg;
                  dataOut_reg <= format_word(modeReg, !narrowBus, is3g && cfgReg.streamSwap,
                                             pendReg, 1'h0);
                  if (narrowBus && (modeReg != sdipo_pkg::MODE_TS)) begin
                     state_reg <= sdipo_pkg::ST_SECOND;
                  end
               end
            end
            sdipo_pkg::ST_SECOND: begin
               dataOut_reg <= format_word(modeReg, !narrowBus, is3g && cfgReg.streamSwap,
                                          curPair, 1'h1);
               state_reg   <= sdipo_pkg::ST_FIRST;
            end
            default: begin
               state_reg <= sdipo_pkg::ST_FIRST;
            end
         endcase
      end
   end

   assign dataOut = dataOut_reg;

   // ******************************************************************
   // Assertions
   // ******************************************************************
   sequence s_wide_take;
      takePend && (modeReg == sdipo_pkg::MODE_VIDEO) && !narrowBus;
   endsequence

   sequence s_mux_take;
      takePend && (modeReg == sdipo_pkg::MODE_VIDEO) && narrowBus && !is3g;
   endsequence

   a_low_bits_zero: assert property (@(posedge pixClk) disable iff (rst)
      (slotTick && (state_reg == sdipo_pkg::ST_SECOND)) |=> (dataOut_reg[9:0] == 10'h000))
      else $error("lower bits not low in narrow output");

   a_mux_order: assert property (@(posedge pixClk) disable iff (rst)
      s_mux_take |=> (dataOut_reg[19:10] == $past(pendReg.wordA))
                     ##2 (dataOut_reg[19:10] == $past(pendReg.wordB, 3)))
      else $error("multiplexed word order wrong");

   a_wide_demux: assert property (@(posedge pixClk) disable iff (rst)
      (s_wide_take and (!is3g || !cfgReg.streamSwap))
      |=> (dataOut_reg == {$past(pendReg.wordA), $past(pendReg.wordB)}))
      else $error("wide output not demultiplexed");

   a_stream_swap: assert property (@(posedge pixClk) disable iff (rst)
      (s_wide_take and (is3g && cfgReg.streamSwap))
      |=> (dataOut_reg == {$past(pendReg.wordB), $past(pendReg.wordA)}))
      else $error("3G streams not swapped");

   a_ts_format: assert property (@(posedge pixClk) disable iff (rst)
      (takePend && (modeReg == sdipo_pkg::MODE_TS))
      |=> (dataOut_reg == {$past(pendReg.codeErrorFlag), $past(pendReg.syncCharacterFlag),
                           $past(pendReg.tsByte), 10'h000}))
      else $error("transport word layout wrong");

   a_ts_entry: assert property (@(posedge pixClk) disable iff (rst)
      (modeReg == sdipo_pkg::MODE_TS) |-> (!$past(cfgReg.autoDetectEnable) &&
         !$past(cfgReg.videoProcessingSelect) && $past(cfgReg.transportStreamSelect)))
      else $error("transport mode entered wrongly");

   a_thru_select: assert property (@(posedge pixClk) disable iff (rst)
      (!cfgReg.videoProcessingSelect && !cfgReg.transportStreamSelect)
      |=> (modeReg == sdipo_pkg::MODE_THRU))
      else $error("data-through not selected");

   a_sd_rates: assert property (@(posedge pixClk) disable iff (rst)
      rateCode[0] |=> (rateReg == ($past(cfgReg.busWidthSelect) ?
                                   sdipo_pkg::RATE_13M5 : sdipo_pkg::RATE_27M)))
      else $error("SD clock rate wrong");

   a_hd_rates: assert property (@(posedge pixClk) disable iff (rst)
      (rateCode == sdipo_pkg::RATE_CODE_HD) |=> (rateReg == ($past(cfgReg.busWidthSelect) ?
                                   sdipo_pkg::RATE_74M25 : sdipo_pkg::RATE_148M5)))
      else $error("HD clock rate wrong");

   a_ddr_only_3g: assert property (@(posedge pixClk) disable iff (rst)
      ddrActive_reg |-> ((rateReg == sdipo_pkg::RATE_148M5) &&
                         (modeReg == sdipo_pkg::MODE_VIDEO)))
      else $error("DDR outside 3G video");

   a_ddr_edges: assert property (@(posedge pixClk) disable iff (rst)
      (ddrActive_reg && slotTick) |=> (pclk_reg == $past(pclk_reg)))
      else $error("DDR clock edge at word change");

   a_delay_safe: assert property (@(posedge pixClk) disable iff (rst)
      ($changed(fine_reg) || $changed(quad_reg)) |-> !pclk_reg)
      else $error("delay changed during high phase");

   a_ready_drop: assert property (@(posedge clk) disable iff (rst)
      (wordValid && wordReady_reg) |=> !wordReady_reg [*2])
      else $error("ready stayed high after a take");

endmodule : sdipo_par_out

// ==== verif/sdipo_sink.sv ====
`timescale 1ns/1ps
// Downstream sampler; keeps every captured word for the bench to inspect.
module sdipo_sink (
   // Link side of the parallel bus
   input wire logic        pclkOut,
   input wire logic        ddrActive,
   input wire logic [19:0] dataOut
);
   logic [19:0] seen [$];
   // Rising edges always capture.
   always @(posedge pclkOut) seen.push_back(dataOut);
   // Falling edges capture too, but only in double-data-rate mode.
   always @(negedge pclkOut) if (ddrActive) seen.push_back(dataOut);
endmodule : sdipo_sink

// ==== verif/sdi_rx_parallel_output_port_test.sv ====
`timescale 1ns/1ps
// Random and corner configurations of the parallel output port.
module sdi_rx_parallel_output_port_test;
   logic clk = 0, rst = 1, pixClk = 0, wordValid = 0, regWrEn = 0, regRdEn = 0, wordReady;
   logic [11:0] regAddr = '0;
   logic [15:0] regWrData = '0, regRdData;
   logic [19:0] dataOut, w0, w1;
   logic pclkOut, quad, frac, ddr;
   logic [4:0] fine;
   logic [1:0] code;
   logic [6:0] cases [8] = '{7'h39, 7'h50, 7'h23, 7'h40, 7'h03, 7'h4a, 7'h52, 7'h3e};
   sdipo_pkg::sdipo_cfg_s cfg = '0;
   sdipo_pkg::sdipo_pair_s p = '0;
   sdipo_pkg::sdipo_rate_e rateSel;
   sdipo_pkg::sdipo_mode_e mode;
   int n_fail = 0, total_checks = 0;
   sdipo_par_out DUT (.clk(clk), .rst(rst), .pixClk(pixClk),
      .videoProcessingSelect(cfg.videoProcessingSelect),
      .transportStreamSelect(cfg.transportStreamSelect), .busWidthSelect(cfg.busWidthSelect),
      .autoDetectEnable(cfg.autoDetectEnable), .streamSwap(cfg.streamSwap),
      .fracRate(cfg.fracRate), .rateSelect(cfg.rateSelect), .rateDetected(cfg.rateDetected),
      .wordValid(wordValid), .wordIn(p), .wordReady(wordReady), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .dataOut(dataOut), .pclkOut(pclkOut), .clockQuadratureSelect(quad),
      .clockFineDelay(fine), .pclkRateSel(rateSel), .pclkFracSel(frac),
      .ddrActive(ddr), .modeStatus(mode));
   sdipo_sink sink (.pclkOut(pclkOut), .ddrActive(ddr), .dataOut(dataOut));
   // Core clock at 250 MHz; the link clock is offset so the edges never line up.
   always #2 clk = ~clk;
   always begin
      #0.7;
      forever #15 pixClk = ~pixClk;
   end
   task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic finish_test;
      if (n_fail == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task automatic pixWait(input int n);
      repeat (n) @(posedge pixClk);
      @(negedge clk);
   endtask : pixWait
   task automatic regAcc(input logic wr, input logic [11:0] a, input logic [15:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = wr;
      regRdEn = !wr;
      @(negedge clk);
      {regWrEn, regRdEn} = 2'b00;
      @(negedge clk);
      if (!wr) cmp({4'h0, regRdData}, {4'h0, d});
   endtask : regAcc
   // The handshake is bounded so a stuck port ends the run.
   task automatic waitReady;
      for (int i = 0; i < 400 && wordReady !== 1'b1; i++) @(negedge clk);
      if (wordReady !== 1'b1) begin
         n_fail++;
         finish_test();
      end
   endtask : waitReady
   initial begin
      logic th, found;
      void'($urandom(32'h953b1be8));
      pixWait(4);
      rst = 0;
      pixWait(6);
      regAcc(0, 12'h06c, 16'h0000);
      regAcc(1, 12'h06c, 16'h0014);
      regAcc(0, 12'h06c, 16'h0014);
      regAcc(1, 12'h06d, 16'hffff);
      regAcc(0, 12'h06d, 16'h0000);
      pixWait(12);
      cmp({quad, fine}, 20'h00014);
      regAcc(1, 12'h06c, 16'hffff);
      regAcc(0, 12'h06c, 16'h003f);
      pixWait(12);
      cmp({quad, fine}, 20'h0003f);
      for (int k = 0; k < 24; k++) begin
         cfg = $urandom;
         if (k < 8) {cfg.videoProcessingSelect, cfg.transportStreamSelect,
            cfg.busWidthSelect, cfg.autoDetectEnable, cfg.rateSelect, cfg.streamSwap} = cases[k];
         if (cfg.transportStreamSelect) cfg.busWidthSelect = 0;
         p = $urandom;
         p.wordB = ~p.wordA;
         code = cfg.autoDetectEnable ? cfg.rateDetected : cfg.rateSelect;
         th = cfg.videoProcessingSelect && code == 2'h2 && cfg.streamSwap;
         pixWait(10);
         if (!cfg.autoDetectEnable && !cfg.videoProcessingSelect && cfg.transportStreamSelect)
         begin
            cmp(mode, 20'h2);
            w0 = {p.codeErrorFlag, p.syncCharacterFlag, p.tsByte, 10'h000};
            w1 = w0;
         end else begin
            cmp(mode, cfg.videoProcessingSelect ? 20'h1 : 20'h4);
            w0 = th ? {p.wordB, p.wordA} : {p.wordA, p.wordB};
            w1 = w0;
            if (!cfg.busWidthSelect) {w0, w1} = {w0[19:10], 10'h0, w0[9:0], 10'h0};
         end
         cmp(rateSel, code[0] ? (cfg.busWidthSelect ? 1 : 2) :
             (code == 2'h2 || !cfg.busWidthSelect) ? 8 : 4);
         cmp(ddr, cfg.videoProcessingSelect && !cfg.busWidthSelect && code == 2'h2);
         cmp(frac, cfg.fracRate);
         waitReady();
         sink.seen.delete();
         wordValid = 1;
         @(negedge clk);
         wordValid = 0;
         waitReady();
         pixWait(12);
         found = 0;
         for (int i = 0; i + 1 < sink.seen.size(); i++)
            if (sink.seen[i] === w0 && sink.seen[i + 1] === w1) found = 1;
         cmp(found, 20'h1);
      end
      finish_test();
   end
endmodule : sdi_rx_parallel_output_port_test
